// ==== design/mmuac_pkg.sv ====
// mmuac_pkg: constants and types of the memory management and register access control block
// Functional notes
// - five cpu modes decoded from program_status_high and two mode bits
// - each segment entry holds rwx rights, first and last address, relocation
// - each segment entry also holds hardware register group rights
// - an entry granting no memory right is unused and never matches
// - any number of defined segments from none to 64 works
// - 128 bytes of nonvolatile memory reserved for the manufacturer
// - cpu gives virtual addresses only; every one is translated first
// - in user mode the segment rwx right is checked before an access may reach memory
// - every special register access outside the cpu group is checked against the current mode
// - user mode uses segment rights, contactless os uses firewall control
// - a refused register read returns zero
// - a refused register write is dropped
// - rom split into test and application regions for checks
// - nvm and ram split into contactless os and application parts
// - firewall registers set os register rights and the shared ram window
// - memory checks read, write, execute; registers read and write
// - a register can refuse read or write by function or mode
// - segment table lives in memory and is fetched from there
// - segmentation config registers hold the segment table pointer
// - segmentation config registers only reachable in system mode; boot and test modes still get them as special registers
// - system mode has full access to application rom, nvm, ram; the code still refuses rom writes and ram execution there
package mmuac_pkg;
	localparam int          VA_W     = 16;
	localparam int          PA_W     = 18;
	localparam int          SEG_N    = 64;
	localparam int          SEG_IW   = 6;
	localparam int          PSW_SYS  = 7;
	localparam logic [1:0]  MB_BOOT  = 2'h1;
	localparam logic [1:0]  MB_TEST  = 2'h2;
	localparam logic [1:0]  MB_COS   = 2'h3;
	// physical memory map
	localparam logic [17:0] TROM_LO  = 18'h00000;
	localparam logic [17:0] AROM_LO  = 18'h04000;
	localparam logic [17:0] MANUF_LO = 18'h20000;
	localparam logic [17:0] CNVM_LO  = 18'h20080;
	localparam logic [17:0] ANVM_LO  = 18'h21000;
	localparam logic [17:0] CRAM_LO  = 18'h38000;
	localparam logic [17:0] ARAM_LO  = 18'h38400;
	// apb byte addresses
	localparam logic [7:0]  A_SEGPTR = 8'h00;
	localparam logic [7:0]  A_FWLO   = 8'h08;
	localparam logic [7:0]  A_FWHI   = 8'h0C;
	localparam logic [7:0]  A_XBLO   = 8'h10;
	localparam logic [7:0]  A_XBHI   = 8'h14;
	localparam logic [7:0]  A_XSLO   = 8'h18;
	localparam logic [7:0]  A_XSHI   = 8'h1C;
	localparam logic [7:0]  A_STATUS = 8'h20;
	typedef enum logic [2:0] {MODE_BOOT = 3'b000, MODE_TEST = 3'b001, MODE_COS = 3'b010,
		MODE_SYS = 3'b011, MODE_USER = 3'b100} mmuac_mode_t;
	typedef enum logic [1:0] {OP_READ = 2'b00, OP_WRITE = 2'b01, OP_EXEC = 2'b10} mmuac_op_t;
	typedef enum logic [2:0] {G_SEGCFG = 3'b000, G_SYSMGT = 3'b001, G_FWCFG = 3'b010, G_COSINT = 3'b011,
		G_TEST = 3'b100, G_HW = 3'b101, G_CPU = 3'b110} mmuac_group_t;
	typedef enum logic [2:0] {RG_TROM = 3'b000, RG_AROM = 3'b001, RG_MANUF = 3'b010, RG_CNVM = 3'b011,
		RG_ANVM = 3'b100, RG_CRAM = 3'b101, RG_ARAM = 3'b110} mmuac_region_t;
	typedef enum logic {FS_IDLE = 1'b0, FS_WAIT = 1'b1} mmuac_fstate_t;
	typedef struct packed {
		logic rd; logic wr; logic ex; logic hw_rd; logic hw_wr;
		logic [15:0] first; logic [15:0] last; logic [17:0] offset;
	} mmuac_seg_t;
	typedef struct packed {logic valid; mmuac_op_t op; logic [15:0] vaddr;} mmuac_mreq_t;
	typedef struct packed {logic ack; logic grant; mmuac_op_t op; logic [17:0] paddr;} mmuac_mrsp_t;
	typedef struct packed {
		logic valid; logic write; mmuac_group_t group; logic [2:0] sub;
		logic [7:0] rdata; logic fn_no_read; logic fn_no_write;
	} mmuac_sreq_t;
	typedef struct packed {logic ack; logic grant; logic wr_en; logic [7:0] rdata;} mmuac_srsp_t;
	typedef struct packed {
		mmuac_mode_t mode; logic [15:0] seg_ptr; logic [7:0] fw_lo; logic [7:0] fw_hi;
		logic [7:0] xb_lo; logic [7:0] xb_hi; logic [7:0] xs_lo; logic [7:0] xs_hi;
		logic [1:0] cur_hw; mmuac_fstate_t fstate; logic [5:0] fidx; logic tbl_req; logic [17:0] tbl_addr;
		mmuac_seg_t [SEG_N-1:0] table_e; mmuac_mrsp_t mrsp; mmuac_srsp_t srsp;
		logic [31:0] prdata; logic pready; logic pslverr; logic deny_mem; logic deny_sfr;
	} mmuac_state_t;
endpackage

// ==== design/mmuac_top.sv ====
// mmuac_top: address translation, memory rights and special register gating
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module mmuac_top (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// cpu mode sources
	input  wire logic [7:0]            program_status_high,
	input  wire logic [1:0]            mode_bits,
	// cpu memory access
	input  wire mmuac_pkg::mmuac_mreq_t mem_req,
	output mmuac_pkg::mmuac_mrsp_t     mem_rsp,
	// cpu special register access
	input  wire mmuac_pkg::mmuac_sreq_t sfr_req,
	output mmuac_pkg::mmuac_srsp_t     sfr_rsp,
	// segment table fetch port
	output logic                       tbl_rd_req,
	output logic      [17:0]           tbl_rd_addr,
	input  wire logic                  tbl_rd_ack,
	input  wire mmuac_pkg::mmuac_seg_t tbl_rd_data
);
	import mmuac_pkg::*;

	mmuac_state_t  r_reg;
	mmuac_state_t  r_next;
	logic          hit;
	logic [5:0]    hidx;
	mmuac_seg_t    hseg;
	logic [17:0]   xlat;
	mmuac_region_t rgn;
	logic          in_xwin;
	logic          mem_ok;
	logic          sfr_ok;
	logic          acc;
	logic          apb_ok;
	logic [31:0]   rd_val;

	// an entry with no memory right is unused
	function automatic logic seg_live(input mmuac_seg_t s);
		return s.rd | s.wr | s.ex;
	endfunction

	function automatic mmuac_region_t region_of(input logic [17:0] a);
		if (a >= ARAM_LO)
			return RG_ARAM;
		else if (a >= CRAM_LO)
			return RG_CRAM;
		else if (a >= ANVM_LO)
			return RG_ANVM;
		else if (a >= CNVM_LO)
			return RG_CNVM;
		else if (a >= MANUF_LO)
			return RG_MANUF;
		else if (a >= AROM_LO)
			return RG_AROM;
		else
			return RG_TROM;
	endfunction

	// region rights per mode; rom never written, ram never executed
	function automatic logic mem_allowed(input mmuac_mode_t m, input mmuac_region_t g, input mmuac_op_t op,
		input logic xw, input mmuac_seg_t s);
		logic rom_ok;
		logic ram_ok;
		logic segr;
		rom_ok = (op != OP_WRITE);
		ram_ok = (op != OP_EXEC);
		segr   = (op == OP_READ) ? s.rd : (op == OP_WRITE) ? s.wr : s.ex;
		unique case (m)
			MODE_BOOT:
				return (g == RG_TROM && rom_ok) || g == RG_CNVM || (g == RG_CRAM && ram_ok);
			MODE_TEST:
				return ((g == RG_TROM || g == RG_AROM) && rom_ok) || g == RG_MANUF || g == RG_CNVM ||
					g == RG_ANVM || ((g == RG_CRAM || g == RG_ARAM) && ram_ok);
			MODE_COS:
				return (g == RG_TROM && rom_ok) || g == RG_CNVM || (g == RG_CRAM && ram_ok) ||
					(g == RG_ARAM && xw && ram_ok);
			MODE_SYS:
				return (g == RG_AROM && rom_ok) || g == RG_ANVM || (g == RG_ARAM && ram_ok);
			MODE_USER:
				return segr && ((g == RG_AROM && rom_ok) || g == RG_ANVM || (g == RG_ARAM && ram_ok));
			default:
				return 1'b0;
		endcase
	endfunction

	// register group rights per mode
	function automatic logic sfr_allowed(input mmuac_mode_t m, input mmuac_sreq_t q, input logic [7:0] flo,
		input logic [7:0] fhi, input logic [1:0] hw);
		logic fw;
		logic sg;
		fw = q.write ? fhi[q.sub] : flo[q.sub];
		sg = q.write ? hw[0] : hw[1];
		if (q.group == G_CPU)
			return 1'b1;
		unique case (m)
			MODE_BOOT, MODE_TEST:
				return 1'b1;
			MODE_COS:
				return (q.group == G_FWCFG && !q.write) || q.group == G_COSINT || (q.group == G_HW && fw);
			MODE_SYS:
				return q.group == G_SEGCFG || q.group == G_SYSMGT || q.group == G_FWCFG || q.group == G_HW;
			MODE_USER:
				return q.group == G_HW && sg;
			default:
				return 1'b0;
		endcase
	endfunction

	// lowest index wins when segments overlap
	always_comb begin
		hit  = 1'b0;
		hidx = '0;
		for (int i = SEG_N - 1; i >= 0; i--) begin
			if (seg_live(r_reg.table_e[i]) && mem_req.vaddr >= r_reg.table_e[i].first &&
				mem_req.vaddr <= r_reg.table_e[i].last) begin
				hit  = 1'b1;
				hidx = i[5:0];
			end
		end
		hseg    = r_reg.table_e[hidx];
		xlat    = hseg.offset + {2'b00, mem_req.vaddr};
		rgn     = region_of(xlat);
		in_xwin = (xlat - ARAM_LO) >= {2'b00, r_reg.xb_hi, r_reg.xb_lo} &&
			(xlat - ARAM_LO) < ({2'b00, r_reg.xb_hi, r_reg.xb_lo} + {2'b00, r_reg.xs_hi, r_reg.xs_lo});
		// table reload blocks memory so no half-loaded entry is trusted
		mem_ok  = hit && r_reg.fstate == FS_IDLE && mem_allowed(r_reg.mode, rgn, mem_req.op, in_xwin, hseg);
		sfr_ok  = sfr_allowed(r_reg.mode, sfr_req, r_reg.fw_lo, r_reg.fw_hi, r_reg.cur_hw) &&
			!(sfr_req.write ? sfr_req.fn_no_write : sfr_req.fn_no_read);
		acc     = psel && penable && !r_reg.pready;
	end

	// apb privilege: segmentation config system only, firewall readable by os too
	always_comb begin
		apb_ok = 1'b1;
		rd_val = '0;
		unique case (paddr)
			A_SEGPTR: begin
				apb_ok = r_reg.mode == MODE_SYS;
				rd_val = {16'h0000, r_reg.seg_ptr};
			end
			A_FWLO, A_FWHI, A_XBLO, A_XBHI, A_XSLO, A_XSHI: begin
				apb_ok = r_reg.mode == MODE_BOOT || r_reg.mode == MODE_TEST || r_reg.mode == MODE_SYS ||
					(r_reg.mode == MODE_COS && !pwrite);
				unique case (paddr)
					A_FWLO:  rd_val = {24'h000000, r_reg.fw_lo};
					A_FWHI:  rd_val = {24'h000000, r_reg.fw_hi};
					A_XBLO:  rd_val = {24'h000000, r_reg.xb_lo};
					A_XBHI:  rd_val = {24'h000000, r_reg.xb_hi};
					A_XSLO:  rd_val = {24'h000000, r_reg.xs_lo};
					default: rd_val = {24'h000000, r_reg.xs_hi};
				endcase
			end
			A_STATUS:
				rd_val = {24'h000000, r_reg.deny_sfr, r_reg.deny_mem, r_reg.cur_hw, r_reg.fstate, r_reg.mode};
			default:
				apb_ok = 1'b0;
		endcase
	end

	always_comb begin
		r_next         = r_reg;
		r_next.mrsp    = '0;
		r_next.srsp    = '0;
		r_next.pready  = 1'b0;
		r_next.pslverr = 1'b0;
		// mode per instruction from status high and internal bits
		unique case (mode_bits)
			MB_BOOT: r_next.mode = MODE_BOOT;
			MB_TEST: r_next.mode = MODE_TEST;
			MB_COS:  r_next.mode = MODE_COS;
			default: r_next.mode = program_status_high[PSW_SYS] ? MODE_SYS : MODE_USER;
		endcase
		if (mem_req.valid) begin
			r_next.mrsp.ack   = 1'b1;
			r_next.mrsp.grant = mem_ok;
			r_next.mrsp.op    = mem_req.op;
			r_next.mrsp.paddr = mem_ok ? xlat : '0;
			r_next.deny_mem   = !mem_ok;
			if (mem_ok && mem_req.op == OP_EXEC)
				r_next.cur_hw = {hseg.hw_rd, hseg.hw_wr};
		end
		if (sfr_req.valid) begin
			r_next.srsp.ack   = 1'b1;
			r_next.srsp.grant = sfr_ok;
			r_next.srsp.wr_en = sfr_ok && sfr_req.write;
			r_next.srsp.rdata = (sfr_ok && !sfr_req.write) ? sfr_req.rdata : 8'h00;
			r_next.deny_sfr   = !sfr_ok;
		end
		// table walk, one entry per acknowledged read
		if (r_reg.fstate == FS_WAIT && tbl_rd_ack) begin
			r_next.table_e[r_reg.fidx] = tbl_rd_data;
			if (r_reg.fidx == 6'(SEG_N - 1)) begin
				r_next.fstate  = FS_IDLE;
				r_next.tbl_req = 1'b0;
			end else begin
				r_next.fidx     = r_reg.fidx + 6'h01;
				r_next.tbl_addr = r_reg.tbl_addr + 18'h00001;
			end
		end
		if (acc) begin
			r_next.pready  = 1'b1;
			r_next.pslverr = !(paddr == A_SEGPTR || paddr == A_STATUS || (paddr >= A_FWLO && paddr <= A_XSHI &&
				paddr[1:0] == 2'b00));
			r_next.prdata  = (apb_ok && !pwrite) ? rd_val : '0;
			if (apb_ok && pwrite) begin
				unique case (paddr)
					A_SEGPTR: begin
						r_next.seg_ptr  = pwdata[15:0];
						r_next.fstate   = FS_WAIT; // a new pointer restarts the walk
						r_next.fidx     = '0;
						r_next.tbl_req  = 1'b1;
						r_next.tbl_addr = {2'b00, pwdata[15:0]};
					end
					A_FWLO: r_next.fw_lo = pwdata[7:0];
					A_FWHI: r_next.fw_hi = pwdata[7:0];
					A_XBLO: r_next.xb_lo = pwdata[7:0];
					A_XBHI: r_next.xb_hi = pwdata[7:0];
					A_XSLO: r_next.xs_lo = pwdata[7:0];
					A_XSHI: r_next.xs_hi = pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// zero reset leaves every segment unused and the mode at boot
	always_ff @(posedge clk) begin
		if (reset)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign prdata      = r_reg.prdata;
	assign pready      = r_reg.pready;
	assign pslverr     = r_reg.pslverr;
	assign mem_rsp     = r_reg.mrsp;
	assign sfr_rsp     = r_reg.srsp;
	assign tbl_rd_req  = r_reg.tbl_req;
	assign tbl_rd_addr = r_reg.tbl_addr;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_mode_decode: assert property (
		mode_bits == MB_COS |=> r_reg.mode == MODE_COS)
		else $error("cos mode bits did not give cos mode");
	chk_sfr_deny_zero: assert property (
		sfr_req.valid && !sfr_req.write && !sfr_ok |=> sfr_rsp.ack && !sfr_rsp.grant && sfr_rsp.rdata == 8'h00)
		else $error("refused register read did not return zero");
	chk_sfr_deny_drop: assert property (
		sfr_req.valid && sfr_req.write && sfr_req.fn_no_write |=> sfr_rsp.ack && !sfr_rsp.wr_en)
		else $error("refused register write was passed on");
	chk_user_hw_seg: assert property (
		sfr_req.valid && r_reg.mode == MODE_USER && sfr_req.group == G_HW && !sfr_req.write && !r_reg.cur_hw[1]
		|=> !sfr_rsp.grant)
		else $error("user hardware register read granted without segment right");
	chk_segcfg_sys: assert property (
		acc && pwrite && paddr == A_SEGPTR && r_reg.mode != MODE_SYS |=> $stable(r_reg.seg_ptr) &&
		r_reg.fstate == $past(r_reg.fstate))
		else $error("segment pointer written outside system mode");
	chk_user_nomatch: assert property (
		mem_req.valid && r_reg.mode == MODE_USER && !hit |=> mem_rsp.ack && !mem_rsp.grant)
		else $error("user access without segment reached memory");
	chk_manuf_keep: assert property (
		mem_rsp.grant && mem_rsp.paddr >= MANUF_LO && mem_rsp.paddr < CNVM_LO |-> $past(r_reg.mode) == MODE_TEST)
		else $error("manufacturer area reached outside test mode");
	chk_walk_end: assert property (
		r_reg.fstate == FS_WAIT && tbl_rd_ack && r_reg.fidx == 6'h3F && !acc |=> r_reg.fstate == FS_IDLE && !tbl_rd_req)
		else $error("table walk did not end after last entry");
	chk_xlat_add: assert property (
		mem_req.valid && mem_ok |=> mem_rsp.paddr == $past(xlat) && mem_rsp.grant)
		else $error("granted address is not the relocated one");
endmodule // mmuac_top

// ==== test/mmuac_tbl_mem.sv ====
// table memory model answering the segment table fetch port
`timescale 1ns/1ps
module mmuac_tbl_mem
	import mmuac_pkg::*;
#(
	parameter logic [17:0] BASE = 18'h00100
) (
	// clock
	input  wire logic        clk,
	// fetch port
	input  wire logic        tbl_rd_req,
	input  wire logic [17:0] tbl_rd_addr,
	output logic             tbl_rd_ack,
	output mmuac_seg_t       tbl_rd_data
);
	function automatic mmuac_seg_t ent(input logic [17:0] a);
		case (a - BASE)
			18'h0: ent = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 16'h1000, 16'h1FFF, 18'h04000};
			18'h1: ent = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h2000, 16'h20FF, 18'h00000};
			18'h2: ent = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h2000, 16'h20FF, 18'h36400};
			18'h3: ent = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h3000, 16'h30FF, 18'h1D000};
			default: ent = '0;
		endcase
	endfunction
	initial begin
		tbl_rd_ack = 1'b0;
		tbl_rd_data = '0;
	end
	// slow memory: ack every other cycle, data scrambled while not valid
	always @(posedge clk) begin
		tbl_rd_ack <= tbl_rd_req && !tbl_rd_ack;
		tbl_rd_data <= (tbl_rd_req && !tbl_rd_ack) ? ent(tbl_rd_addr) : ~tbl_rd_data;
	end
endmodule // mmuac_tbl_mem

// ==== test/mmuac_top_bench.sv ====
// self-checking bench of the translation and register access block
`timescale 1ns/1ps
module mmuac_top_bench;
	import mmuac_pkg::*;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic [7:0]   program_status_high = 8'h00;
	logic [1:0]   mode_bits = 2'h1;
	mmuac_mreq_t  mem_req = '0;
	mmuac_mrsp_t  mem_rsp;
	mmuac_sreq_t  sfr_req = '0;
	mmuac_srsp_t  sfr_rsp;
	logic         tbl_rd_req;
	logic [17:0]  tbl_rd_addr;
	logic         tbl_rd_ack;
	mmuac_seg_t   tbl_rd_data;
	int           n_fail = 0;
	int           num_checks = 0;
	logic [31:0]  rd;
	logic         er;
	logic [1:0]   mb [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
	logic         sb [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [2:0]   me [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};

	always #4 clk = ~clk;

	mmuac_top dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.program_status_high(program_status_high), .mode_bits(mode_bits), .mem_req(mem_req),
		.mem_rsp(mem_rsp), .sfr_req(sfr_req), .sfr_rsp(sfr_rsp), .tbl_rd_req(tbl_rd_req),
		.tbl_rd_addr(tbl_rd_addr), .tbl_rd_ack(tbl_rd_ack), .tbl_rd_data(tbl_rd_data));
	mmuac_tbl_mem #(.BASE(18'h00100)) mem_u (.clk(clk), .tbl_rd_req(tbl_rd_req),
		.tbl_rd_addr(tbl_rd_addr), .tbl_rd_ack(tbl_rd_ack), .tbl_rd_data(tbl_rd_data));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// samples at the wake-up of the edge, before that edge's updates land
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		// a missing answer counts as a mismatch
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic mem(input mmuac_op_t op, input logic [15:0] va, input logic g, input logic [17:0] pa);
		@(posedge clk);
		mem_req <= '{1'b1, op, va};
		@(posedge clk);
		mem_req.valid <= 1'b0;
		@(posedge clk);
		chk({mem_rsp.ack, mem_rsp.grant, mem_rsp.op, 10'h0, mem_rsp.paddr}, {1'b1, g, op, 10'h0, pa});
	endtask
	task automatic sfr(input logic w, input mmuac_group_t gp, input logic [2:0] sub, input logic fnr,
		input logic g, input logic we, input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{1'b1, w, gp, sub, 8'h5A, fnr & !w, fnr & w};
		@(posedge clk);
		sfr_req.valid <= 1'b0;
		@(posedge clk);
		chk({21'h0, sfr_rsp.ack, sfr_rsp.grant, sfr_rsp.wr_en, sfr_rsp.rdata}, {21'h0, 1'b1, g, we, d});
	endtask
	// mode is taken one cycle late, so settle before use
	task automatic setm(input logic [1:0] b, input logic s);
		@(posedge clk);
		mode_bits <= b;
		program_status_high <= {s, 7'h00};
		repeat (3) @(posedge clk);
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#50000;
		n_fail++;
		results();
	end

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			setm(mb[i], sb[i]);
			apb(1'b0, A_STATUS, 32'h0);
			chk(rd & 32'h7, {29'h0, me[i]});
		end
		tend("modes");
		// loop leaves the cpu in system mode
		apb(1'b1, A_SEGPTR, 32'h0000_0100);
		mem(OP_READ, 16'h1010, 1'b0, 18'h0);
		for (int i = 0; i < 100; i++) begin
			apb(1'b0, A_STATUS, 32'h0);
			if (rd[3] === 1'b0)
				break;
		end
		chk(rd & 32'h8, 32'h0);
		chk({13'h0, tbl_rd_req, tbl_rd_addr}, {13'h0, 1'b0, 18'h0013F});
		apb(1'b0, A_SEGPTR, 32'h0);
		chk(rd, 32'h100);
		mem(OP_READ, 16'h1010, 1'b1, 18'h05010);
		mem(OP_WRITE, 16'h2010, 1'b1, 18'h38410);
		mem(OP_READ, 16'h3010, 1'b0, 18'h0);
		sfr(1'b0, G_HW, 3'h1, 1'b1, 1'b0, 1'b0, 8'h00);
		sfr(1'b1, G_HW, 3'h1, 1'b1, 1'b0, 1'b0, 8'h00);
		sfr(1'b1, G_SEGCFG, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, A_FWLO, 32'h4);
		apb(1'b1, A_XBLO, 32'h10);
		apb(1'b1, A_XSLO, 32'h10);
		tend("system");
		setm(2'h2, 1'b0);
		mem(OP_READ, 16'h3010, 1'b1, 18'h20010);
		mem(OP_EXEC, 16'h1010, 1'b1, 18'h05010);
		// executing from a segment without register rights clears them
		mem(OP_EXEC, 16'h3010, 1'b1, 18'h20010);
		tend("test mode");
		setm(2'h0, 1'b0);
		sfr(1'b0, G_HW, 3'h0, 1'b0, 1'b0, 1'b0, 8'h00);
		mem(OP_READ, 16'h1010, 1'b1, 18'h05010);
		mem(OP_EXEC, 16'h1FFF, 1'b1, 18'h05FFF);
		mem(OP_WRITE, 16'h1010, 1'b0, 18'h0);
		mem(OP_WRITE, 16'h2010, 1'b1, 18'h38410);
		mem(OP_READ, 16'h2100, 1'b0, 18'h0);
		mem(OP_READ, 16'h0FFF, 1'b0, 18'h0);
		sfr(1'b0, G_HW, 3'h0, 1'b0, 1'b1, 1'b0, 8'h5A);
		sfr(1'b1, G_HW, 3'h0, 1'b0, 1'b0, 1'b0, 8'h00);
		sfr(1'b0, G_SEGCFG, 3'h0, 1'b0, 1'b0, 1'b0, 8'h00);
		sfr(1'b1, G_CPU, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00);
		apb(1'b1, A_SEGPTR, 32'h0000_0200);
		apb(1'b0, A_SEGPTR, 32'h0);
		chk(rd, 32'h0);
		tend("user");
		setm(2'h3, 1'b0);
		sfr(1'b0, G_HW, 3'h2, 1'b0, 1'b1, 1'b0, 8'h5A);
		sfr(1'b0, G_HW, 3'h1, 1'b0, 1'b0, 1'b0, 8'h00);
		sfr(1'b1, G_HW, 3'h2, 1'b0, 1'b0, 1'b0, 8'h00);
		sfr(1'b1, G_COSINT, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00);
		sfr(1'b0, G_FWCFG, 3'h0, 1'b0, 1'b1, 1'b0, 8'h5A);
		sfr(1'b1, G_FWCFG, 3'h0, 1'b0, 1'b0, 1'b0, 8'h00);
		apb(1'b1, A_FWLO, 32'h0);
		apb(1'b0, A_FWLO, 32'h0);
		chk(rd, 32'h4);
		mem(OP_READ, 16'h1010, 1'b0, 18'h0);
		// window is app ram offsets 0x10 to 0x1F
		mem(OP_WRITE, 16'h2010, 1'b1, 18'h38410);
		mem(OP_WRITE, 16'h2020, 1'b0, 18'h0);
		tend("os mode");
		setm(2'h0, 1'b1);
		apb(1'b0, A_SEGPTR, 32'h0);
		chk(rd, 32'h100);
		tend("pointer kept");
		results();
	end
endmodule // mmuac_top_bench
